// ### hw/led_port_pwm_phase_driver.sv
// sixteen open-drain ports plus extra output, phase banks and pwm intensity
//
// Contract
// [RULE1] phase-0 levels at 0x02 (ports 7..0) and 0x03 (15..8), read back.
// [RULE2] phase-1 levels at 0x0a and 0x0b, readable and writable.
// [RULE3] individual intensity acts only inside master-enabled timeslots.
// [RULE4] intensity picks 1/16 to 16/16 active duration per enabled timeslot.
// [RULE5] full 16/16 level ignores master gate, output static at phase bit.
// [RULE6] alternation off: on-time level from phase-0 bits only.
// [RULE7] phase bit 0: low duty 1/16 up to continuously low.
// [RULE8] phase bit 1: low duty none up to 15/16.
// [RULE9] alternation on: phase-0 or phase-1 bank by current phase.
// [RULE10] extra output's intensity nibble doubles as global intensity.
// [RULE11] global flag applies global intensity to all 17 outputs.
// [RULE12] global mode: master plus global nibble give 240-step control.
// [RULE13] software mixing static and pwm outputs must use individual mode.
// [RULE14] 0x0e below 0x10: all outputs static, global and 0x10-0x17 ignored.
// [RULE15] 0x0e from 0x10 to 0xff enables pwm.
// [RULE16] individual code 0xf is static, 0x0 to 0xe modulate.
// [RULE17] global mode: 0x0e sole intensity source, 0x10-0x17 ignored.
// [RULE18] period is 15 timeslots of 16 pwm cycles, 240 steps.
// [RULE19] master gates individual settings on for 1 to 15 timeslots.
// [RULE20] phase is flip flag xor flip pin; 1 selects phase-1 bank.
// [RULE21] phase bit 1 puts port high impedance, 0 drives it low.
// [RULE22] 0x0e holds master gate high nibble, extra intensity low nibble.
`timescale 1ns/1ps
`default_nettype none
module led_port_pwm_phase_driver #(
  parameter int STEP_DIV_CYCLES = led_pwm_pkg::STEP_DIV_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic alternate_enable_i,
  input wire logic phase_flip_flag_i,
  input wire logic phase_flip_pin_i,
  input wire logic global_mode_i,
  input wire logic extra_phase0_bit_i,
  input wire logic extra_phase1_bit_i,
  output logic [15:0] port_line_o,
  output logic [15:0] port_line_oe_o,
  output logic extra_output_port_o,
  output logic extra_output_port_oe_o
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] phase0_level_low;
    logic [7:0] phase0_level_high;
    logic [7:0] phase1_level_low;
    logic [7:0] phase1_level_high;
    logic [7:0] master_global_intensity;
    logic [63:0] output_intensity;
    logic [led_pwm_pkg::DIV_W-1:0] div;
    logic [3:0] cycle;
    logic [3:0] slot;
    logic [7:0] rdata;
  } drv_state_type;

  localparam logic [led_pwm_pkg::DIV_W-1:0] DIV_LAST = led_pwm_pkg::DIV_W'(STEP_DIV_CYCLES - 1);

  drv_state_type state_reg;
  drv_state_type state_next;
  logic pwm_enable;
  logic phase_sel;
  logic step_en;
  logic slot_gated;
  logic [3:0] master_gate;
  logic [3:0] extra_code;
  logic [15:0] level_bits;
  logic [15:0] drive_low;
  logic [2:0] int_idx;

  always_comb begin
    master_gate = state_reg.master_global_intensity[led_pwm_pkg::MASTER_MSB:led_pwm_pkg::MASTER_LSB]; // [RULE22]
    extra_code = state_reg.master_global_intensity[led_pwm_pkg::EXTRA_CODE_MSB:led_pwm_pkg::EXTRA_CODE_LSB]; // [RULE22]
    pwm_enable = (master_gate != led_pwm_pkg::MASTER_STATIC); // [RULE14] [RULE15]
    phase_sel = alternate_enable_i && (phase_flip_flag_i ^ phase_flip_pin_i); // [RULE20]
    if (phase_sel) begin
      level_bits = {state_reg.phase1_level_high, state_reg.phase1_level_low}; // [RULE9]
    end else begin
      level_bits = {state_reg.phase0_level_high, state_reg.phase0_level_low}; // [RULE6]
    end
    step_en = (state_reg.div == DIV_LAST);
    slot_gated = (state_reg.slot < master_gate); // [RULE19]
    int_idx = reg_addr_i[2:0];
  end

  // -------------------------------------------------------------------
  // registers, pwm timebase and read data
  // -------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (reg_wr_i) begin
      if (reg_addr_i == led_pwm_pkg::ADDR_PHASE0_LOW) begin
        state_next.phase0_level_low = reg_wdata_i; // [RULE1]
      end else if (reg_addr_i == led_pwm_pkg::ADDR_PHASE0_HIGH) begin
        state_next.phase0_level_high = reg_wdata_i; // [RULE1]
      end else if (reg_addr_i == led_pwm_pkg::ADDR_PHASE1_LOW) begin
        state_next.phase1_level_low = reg_wdata_i; // [RULE2]
      end else if (reg_addr_i == led_pwm_pkg::ADDR_PHASE1_HIGH) begin
        state_next.phase1_level_high = reg_wdata_i; // [RULE2]
      end else if (reg_addr_i == led_pwm_pkg::ADDR_MASTER_GLOBAL) begin
        state_next.master_global_intensity = reg_wdata_i;
      end else if (reg_addr_i >= led_pwm_pkg::ADDR_INTENSITY_FIRST &&
                   reg_addr_i <= led_pwm_pkg::ADDR_INTENSITY_LAST) begin
        state_next.output_intensity[int_idx*8 +: 8] = reg_wdata_i;
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == led_pwm_pkg::ADDR_PHASE0_LOW) begin
        state_next.rdata = state_reg.phase0_level_low; // [RULE1]
      end else if (reg_addr_i == led_pwm_pkg::ADDR_PHASE0_HIGH) begin
        state_next.rdata = state_reg.phase0_level_high; // [RULE1]
      end else if (reg_addr_i == led_pwm_pkg::ADDR_PHASE1_LOW) begin
        state_next.rdata = state_reg.phase1_level_low; // [RULE2]
      end else if (reg_addr_i == led_pwm_pkg::ADDR_PHASE1_HIGH) begin
        state_next.rdata = state_reg.phase1_level_high; // [RULE2]
      end else if (reg_addr_i == led_pwm_pkg::ADDR_MASTER_GLOBAL) begin
        state_next.rdata = state_reg.master_global_intensity;
      end else if (reg_addr_i >= led_pwm_pkg::ADDR_INTENSITY_FIRST &&
                   reg_addr_i <= led_pwm_pkg::ADDR_INTENSITY_LAST) begin
        state_next.rdata = state_reg.output_intensity[int_idx*8 +: 8];
      end else begin
        state_next.rdata = led_pwm_pkg::READ_UNMAPPED;
      end
    end
    // timebase parked at zero while static, as the oscillator would be off
    if (!pwm_enable) begin
      state_next.div = '0;
      state_next.cycle = '0;
      state_next.slot = '0;
    end else if (step_en) begin
      state_next.div = '0;
      if (state_reg.cycle == led_pwm_pkg::LAST_CYCLE_IN_SLOT) begin // [RULE18]
        state_next.cycle = '0;
        if (state_reg.slot == led_pwm_pkg::LAST_SLOT) begin // [RULE18]
          state_next.slot = '0;
        end else begin
          state_next.slot = state_reg.slot + 4'h1;
        end
      end else begin
        state_next.cycle = state_reg.cycle + 4'h1;
      end
    end else begin
      state_next.div = state_reg.div + led_pwm_pkg::DIV_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= '0;
      state_reg.phase0_level_low <= led_pwm_pkg::RESET_PHASE;
      state_reg.phase0_level_high <= led_pwm_pkg::RESET_PHASE;
      state_reg.phase1_level_low <= led_pwm_pkg::RESET_PHASE;
      state_reg.phase1_level_high <= led_pwm_pkg::RESET_PHASE;
      state_reg.master_global_intensity <= led_pwm_pkg::RESET_MASTER;
      state_reg.output_intensity <= {led_pwm_pkg::INTENSITY_REGS{led_pwm_pkg::RESET_INTENSITY}};
    end else begin
      state_reg <= state_next;
    end
  end

  // -------------------------------------------------------------------
  // output cells
  // -------------------------------------------------------------------
  // global mode is all-or-nothing: a subset cannot be left static [RULE13]
  for (genvar p = 0; p < led_pwm_pkg::PORTS; p++) begin : g_port
    logic [3:0] code;
    assign code = global_mode_i ? extra_code : state_reg.output_intensity[p*4 +: 4]; // [RULE11] [RULE17] [RULE12]
    pwm_output_cell u_cell (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .level_bit_i(level_bits[p]),
      .code_i(code),
      .pwm_enable_i(pwm_enable),
      .slot_gated_i(slot_gated),
      .cycle_i(state_reg.cycle),
      .drive_low_o(drive_low[p])
    );
  end

  logic extra_drive_low;
  pwm_output_cell u_extra (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .level_bit_i(phase_sel ? extra_phase1_bit_i : extra_phase0_bit_i),
    .code_i(extra_code), // [RULE10]
    .pwm_enable_i(pwm_enable),
    .slot_gated_i(slot_gated),
    .cycle_i(state_reg.cycle),
    .drive_low_o(extra_drive_low)
  );

  assign port_line_o = '0;
  assign port_line_oe_o = drive_low; // [RULE21]
  assign extra_output_port_o = 1'b0;
  assign extra_output_port_oe_o = extra_drive_low;
  assign reg_rdata_o = state_reg.rdata;
endmodule
`default_nettype wire

// ### hw/led_pwm_pkg.sv
// constants shared by the port pwm phase driver
`default_nettype none
package led_pwm_pkg;
  // -------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] ADDR_PHASE0_LOW = 8'h02;
  localparam logic [7:0] ADDR_PHASE0_HIGH = 8'h03;
  localparam logic [7:0] ADDR_PHASE1_LOW = 8'h0a;
  localparam logic [7:0] ADDR_PHASE1_HIGH = 8'h0b;
  localparam logic [7:0] ADDR_MASTER_GLOBAL = 8'h0e;
  localparam logic [7:0] ADDR_INTENSITY_FIRST = 8'h10;
  localparam logic [7:0] ADDR_INTENSITY_LAST = 8'h17;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int MASTER_MSB = 7;
  localparam int MASTER_LSB = 4;
  localparam int EXTRA_CODE_MSB = 3;
  localparam int EXTRA_CODE_LSB = 0;
  localparam int CODE_W = 4;
  localparam int PORTS = 16;
  localparam int INTENSITY_REGS = 8;

  // -------------------------------------------------------------------
  // values after reset
  // -------------------------------------------------------------------
  localparam logic [7:0] RESET_PHASE = 8'hff;
  localparam logic [7:0] RESET_MASTER = 8'h00;
  localparam logic [7:0] RESET_INTENSITY = 8'hff;

  // -------------------------------------------------------------------
  // pwm timing
  // -------------------------------------------------------------------
  localparam logic [3:0] CODE_FULL = 4'hf;
  localparam logic [3:0] MASTER_STATIC = 4'h0;
  localparam logic [3:0] LAST_CYCLE_IN_SLOT = 4'hf;
  localparam logic [3:0] LAST_SLOT = 4'he;
  localparam int CLK_HZ = 200000000;
  localparam int PWM_STEP_HZ = 32000;
  localparam int STEP_DIV_CYCLES = CLK_HZ / PWM_STEP_HZ;
  localparam int DIV_W = 13;
endpackage
`default_nettype wire

// ### hw/pwm_output_cell.sv
// one open-drain output stage: level select, pwm gating, registered enable
`timescale 1ns/1ps
`default_nettype none
module pwm_output_cell (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic level_bit_i,
  input wire logic [3:0] code_i,
  input wire logic pwm_enable_i,
  input wire logic slot_gated_i,
  input wire logic [3:0] cycle_i,
  output logic drive_low_o
);
  typedef struct packed {
    logic drive_low;
  } cell_state_type;

  cell_state_type state_reg;
  cell_state_type state_next;
  logic is_static;
  logic on_time;
  logic level;

  always_comb begin
    is_static = !pwm_enable_i || (code_i == led_pwm_pkg::CODE_FULL); // [RULE5] [RULE14] [RULE16]
    on_time = slot_gated_i && (cycle_i <= code_i); // [RULE3] [RULE4]
    // off-time shows the inverse, so bit 0 never fully off, bit 1 never fully on
    if (is_static) begin
      level = level_bit_i; // [RULE5]
    end else if (on_time) begin
      level = level_bit_i; // [RULE7] [RULE8]
    end else begin
      level = !level_bit_i; // [RULE7] [RULE8]
    end
    state_next.drive_low = !level; // [RULE21]
  end

  // registered so static outputs never glitch on code changes
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign drive_low_o = state_reg.drive_low;
endmodule
`default_nettype wire

// ### test/led_pwm_checker.sv
// assertion checker for the port pwm phase driver
`timescale 1ns/1ps
`default_nettype none
module led_pwm_checker #(
  parameter int STEP_DIV_CYCLES = 2
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic alternate_enable_i,
  input wire logic phase_flip_flag_i,
  input wire logic phase_flip_pin_i,
  input wire logic global_mode_i,
  input wire logic extra_phase0_bit_i,
  input wire logic extra_phase1_bit_i,
  input wire logic [15:0] port_line_o,
  input wire logic [15:0] port_line_oe_o,
  input wire logic extra_output_port_o,
  input wire logic extra_output_port_oe_o
);
  // ----
  // shadow registers, run and settle counters
  // ----
  logic [7:0] sh_q [32];
  logic [9:0] run_q;
  logic [9:0] calm_q;
  logic prev_q;
  logic [25:0] key_q;
  logic sel_ph;
  logic ext_sel;
  logic [15:0] port_sel;
  logic [25:0] key;
  assign sel_ph = alternate_enable_i & (phase_flip_flag_i ^ phase_flip_pin_i);
  assign ext_sel = sel_ph ? extra_phase1_bit_i : extra_phase0_bit_i;
  assign port_sel = sel_ph ? {sh_q[11], sh_q[10]} : {sh_q[3], sh_q[2]};
  assign key = {sh_q[14], ext_sel, port_sel, global_mode_i};
  function automatic logic mapped(input logic [7:0] a);
    return (a inside {8'h02, 8'h03, 8'h0a, 8'h0b, 8'h0e}) || (a[7:3] == 5'h02);
  endfunction
  // counts settle time so duty checks never judge a half-changed period
  always_ff @(posedge ref_clk_i) begin
    prev_q <= extra_output_port_oe_o;
    run_q <= (extra_output_port_oe_o != prev_q) ? 10'h1 : run_q + 10'h1;
    key_q <= key;
    calm_q <= (reset_i || key != key_q) ? 10'h0 : calm_q + {9'h0, calm_q != 10'h3ff};
    for (int i = 0; i < 32; i++) begin
      if (reset_i) begin
        sh_q[i] <= (i == 14) ? 8'h00 : 8'hff;
      end else if (reg_wr_i && mapped(reg_addr_i) && reg_addr_i[4:0] == i) begin
        sh_q[i] <= reg_wdata_i;
      end
    end
  end
  // ----
  // properties
  // ----
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence settled_s;
    calm_q >= 10'd500;
  endsequence
  sequence fall_s;
    $fell(extra_output_port_oe_o);
  endsequence
  a_read_data: assert property (
    reg_rd_i |=> reg_rdata_o == (mapped($past(reg_addr_i)) ? $past(sh_q[reg_addr_i[4:0]]) : 8'h00))
    else $error("read data differs from register contents");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  a_open_drain: assert property (port_line_o == 16'h0000 && !extra_output_port_o)
    else $error("open-drain data not low");
  // enables lag the registers by one edge, so the static condition is taken one edge back
  a_ports_static: assert property (
    (calm_q >= 10'd2 && ($past(sh_q[14][7:4]) == 4'h0 ||
      ($past(global_mode_i) && $past(sh_q[14][3:0]) == 4'hf)))
    |-> port_line_oe_o == ~$past(port_sel))
    else $error("static port enables wrong");
  a_extra_static: assert property (
    (calm_q >= 10'd2 && ($past(sh_q[14][7:4]) == 4'h0 || $past(sh_q[14][3:0]) == 4'hf))
    |-> extra_output_port_oe_o == !$past(ext_sel))
    else $error("static extra output wrong");
  a_min_duty: assert property (
    (settled_s ##0 fall_s ##0 (sh_q[14] == 8'h10 && !ext_sel)) |-> run_q == STEP_DIV_CYCLES)
    else $error("shortest low pulse has wrong length");
  a_hiz_run: assert property (
    (settled_s ##0 $rose(extra_output_port_oe_o) ##0 (sh_q[14] == 8'h10 && ext_sel)) |-> run_q == STEP_DIV_CYCLES)
    else $error("high impedance pulse has wrong length");
  a_slot_run: assert property (
    (settled_s ##0 fall_s ##0 (sh_q[14] == 8'hfe && !ext_sel)) |-> run_q == 15 * STEP_DIV_CYCLES)
    else $error("timeslot low run has wrong length");
endmodule
bind led_port_pwm_phase_driver led_pwm_checker #(.STEP_DIV_CYCLES(STEP_DIV_CYCLES)) chk_u (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .alternate_enable_i(alternate_enable_i), .phase_flip_flag_i(phase_flip_flag_i),
  .phase_flip_pin_i(phase_flip_pin_i), .global_mode_i(global_mode_i),
  .extra_phase0_bit_i(extra_phase0_bit_i), .extra_phase1_bit_i(extra_phase1_bit_i),
  .port_line_o(port_line_o), .port_line_oe_o(port_line_oe_o),
  .extra_output_port_o(extra_output_port_o), .extra_output_port_oe_o(extra_output_port_oe_o));
`default_nettype wire

// ### test/reg_host_model.sv
// host side model driving the register port
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  // ----
  // one strobed transfer per call
  // ----
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // released address and data show the inverse, so stale values cannot pass
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk_i);
    reg_wr_o <= wr;
    reg_rd_o <= !wr;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    #1;
    q = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// ### test/led_port_pwm_phase_driver_tb_top.sv
// self-checking bench for the port pwm phase driver
`timescale 1ns/1ps
`default_nettype none
module led_port_pwm_phase_driver_tb_top;
  // ----
  // bench signals, tasks and sequence
  // ----
  localparam int DIV = 2;
  localparam int PERIOD = 240 * DIV;
  localparam logic [7:0] ADDRS [13] = '{8'h02, 8'h03, 8'h0a, 8'h0b, 8'h0e, 8'h10, 8'h11, 8'h12,
    8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
  logic ref_clk_i, reset_i, alt, flag, pin, glob, x0, x1, sel, wr_s, rd_s, xdata, xoe;
  logic [7:0] addr_s, wdata_s, rdata_s, rd_v;
  logic [15:0] pdata, oe, cnt_x, cnt_0, cnt_1;
  int fails, n_compared;
  led_port_pwm_phase_driver #(.STEP_DIV_CYCLES(DIV)) dut_u (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_addr_i(addr_s),
    .reg_wdata_i(wdata_s), .reg_rdata_o(rdata_s), .alternate_enable_i(alt), .phase_flip_flag_i(flag),
    .phase_flip_pin_i(pin), .global_mode_i(glob), .extra_phase0_bit_i(x0), .extra_phase1_bit_i(x1),
    .port_line_o(pdata), .port_line_oe_o(oe), .extra_output_port_o(xdata), .extra_output_port_oe_o(xoe));
  reg_host_model host_u (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata_s), .reg_wr_o(wr_s), .reg_rd_o(rd_s),
    .reg_addr_o(addr_s), .reg_wdata_o(wdata_s));
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.access(1'b1, a, d, rd_v);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host_u.access(1'b0, a, 8'h00, rd_v);
    check({8'h00, rd_v}, {8'h00, e});
  endtask
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one settling period, then low-drive cycles summed over a full period
  task automatic pwm_case(input logic [7:0] m, input logic g, input logic b, input logic [15:0] ex, e0, e1);
    wr(8'h0e, m);
    @(posedge ref_clk_i);
    glob <= g;
    x0 <= b;
    cnt_x = 16'h0;
    cnt_0 = 16'h0;
    cnt_1 = 16'h0;
    repeat (PERIOD) @(posedge ref_clk_i);
    repeat (PERIOD) begin
      @(posedge ref_clk_i);
      #1;
      cnt_x = cnt_x + {15'h0, xoe};
      cnt_0 = cnt_0 + {15'h0, oe[0]};
      cnt_1 = cnt_1 + {15'h0, oe[1]};
    end
    check(cnt_x, ex);
    check(cnt_0, e0);
    check(cnt_1, e1);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    end_sim;
  end
  initial begin
    fails = 0;
    n_compared = 0;
    {reset_i, alt, flag, pin, glob, x0, x1} = 7'h41;
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    foreach (ADDRS[i]) rd_chk(ADDRS[i], (ADDRS[i] == 8'h0e) ? 8'h00 : 8'hff);
    foreach (ADDRS[i]) begin
      wr(ADDRS[i], {ADDRS[i][3:0], ~ADDRS[i][3:0]});
      rd_chk(ADDRS[i], {ADDRS[i][3:0], ~ADDRS[i][3:0]});
    end
    wr(8'h05, 8'h3c);
    rd_chk(8'h05, 8'h00);
    wr(8'h0e, 8'h0f);
    wr(8'h02, 8'h5a);
    wr(8'h03, 8'hc3);
    wr(8'h0a, 8'h0f);
    wr(8'h0b, 8'hf0);
    wr(8'h10, 8'h00);
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk_i);
      {alt, flag, pin} <= 3'(k);
      repeat (3) @(posedge ref_clk_i);
      #1;
      sel = alt & (flag ^ pin);
      check(oe, sel ? 16'h0ff0 : 16'h3ca5);
      check({15'h0, xoe}, {15'h0, !(sel ? x1 : x0)});
    end
    alt <= 1'b0;
    wr(8'h02, 8'h00);
    wr(8'h10, 8'hf0);
    pwm_case(8'h10, 1'b0, 1'b0, 16'(DIV), 16'(DIV), 16'(PERIOD));
    pwm_case(8'h10, 1'b0, 1'b1, 16'(PERIOD - DIV), 16'(DIV), 16'(PERIOD));
    pwm_case(8'hfe, 1'b0, 1'b0, 16'(225 * DIV), 16'(15 * DIV), 16'(PERIOD));
    pwm_case(8'h10, 1'b1, 1'b0, 16'(DIV), 16'(DIV), 16'(DIV));
    pwm_case(8'h1f, 1'b1, 1'b0, 16'(PERIOD), 16'(PERIOD), 16'(PERIOD));
    // mid-run reset: all ports released and 0x0e and 0x02 read back their reset values
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    #1;
    check(oe, 16'h0000);
    check({15'h0, xoe}, 16'h0000);
    rd_chk(8'h0e, 8'h00);
    rd_chk(8'h02, 8'hff);
    end_sim;
  end
endmodule
`default_nettype wire
